// ---- verilog/ht_cfg.svh ----
// constants for the humidity and temperature readout
`ifndef HT_CFG_SVH
`define HT_CFG_SVH

// -----------------------------------------------------------------
// target address and register offsets
// -----------------------------------------------------------------
`define HT_TGT_ADDR      7'h40
`define HT_REG_STATUS    8'h00
`define HT_REG_RES_HI    8'h01
`define HT_REG_RES_LO    8'h02
`define HT_REG_CTRL      8'h03
`define HT_REG_IDENT     8'h11

// -----------------------------------------------------------------
// control fields and reset values
// -----------------------------------------------------------------
`define HT_CTRL_START    0
`define HT_CTRL_HEAT     1
`define HT_CTRL_TEMP     4
`define HT_CTRL_FAST     5
`define HT_CTRL_MASK     8'h33
`define HT_CTRL_RST      8'h00
`define HT_CTRL_CLEAR    8'h00
`define HT_NRDY_RST      1'b1
`define HT_RES_RST       16'h0000
`define HT_FAST_MASK     16'hfffc
`define HT_CLR_LAST      2'h1

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define HT_MCLK_KHZ      50000
`define HT_CONV_NORM_US  5800
`define HT_CONV_FAST_US  2600
`define HT_CNT_W         19
`define HT_CONV_NORM_CYC (`HT_CONV_NORM_US * `HT_MCLK_KHZ / 1000)
`define HT_CONV_FAST_CYC (`HT_CONV_FAST_US * `HT_MCLK_KHZ / 1000)

`endif

// ---- verilog/ht_pkg.sv ----
// types for the humidity and temperature readout
package ht_pkg;
  typedef enum logic [2:0] {
    LS_IDLE = 3'h0,
    LS_ADDR = 3'h1,
    LS_ACK  = 3'h3,
    LS_RECV = 3'h2,
    LS_SEND = 3'h6,
    LS_RACK = 3'h7
  } ht_link_st_t;
endpackage

// ---- verilog/ht_conv_core.sv ----
// conversion engine, register file and standby control on the main clock
`timescale 1ns/1ps
`include "ht_cfg.svh"

module ht_conv_core #(
  parameter logic [`HT_CNT_W-1:0] NORM_CYC = `HT_CNT_W'(`HT_CONV_NORM_CYC),
  parameter logic [`HT_CNT_W-1:0] FAST_CYC = `HT_CNT_W'(`HT_CONV_FAST_CYC),
  parameter logic [3:0]           DEV_TYPE = 4'h6,  // arbitrary value
  parameter logic [3:0]           DEV_REV  = 4'h2   // arbitrary value
) (
  // clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  // requests from the link side
  input  wire logic        wr_tgl_in,
  input  wire logic [7:0]  wr_ptr_in,
  input  wire logic [7:0]  wr_data_in,
  input  wire logic        rd_tgl_in,
  input  wire logic [7:0]  rd_ptr_in,
  output logic             rsp_tgl_out,
  output logic [15:0]      rsp_word_out,
  // pin and front end
  input  wire logic        chip_select_n_in,
  input  wire logic [13:0] temp_code_in,
  input  wire logic [11:0] hum_code_in,
  // status
  output logic             heater_on_out,
  output logic             standby_out,
  output logic             conv_busy_out
);

  // -----------------------------------------------------------------
  // crossings
  // -----------------------------------------------------------------
  logic [2:0]           s1_ff, s2_ff;
  logic [1:0]           d_ff;
  logic                 wr_evt, rd_evt, cs_hi, ctrl_wr, start_go, done;
  logic [7:0]           ctrl_ff;
  logic                 nrdy_ff, kind_temp_ff, fast_ff, pend_ff, sleep_ff;
  logic [15:0]          result_ff;
  logic [`HT_CNT_W-1:0] cnt_ff;
  logic [1:0]           clr_ff;

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      s1_ff <= 3'h0;
      s2_ff <= 3'h0;
      d_ff  <= 2'h0;
    end else begin
      s1_ff <= {chip_select_n_in, rd_tgl_in, wr_tgl_in};
      s2_ff <= s1_ff;
      d_ff  <= s2_ff[1:0];
    end
  end

  assign wr_evt   = s2_ff[0] ^ d_ff[0];
  assign rd_evt   = s2_ff[1] ^ d_ff[1];
  assign cs_hi    = s2_ff[2];
  assign ctrl_wr  = wr_evt && (wr_ptr_in == `HT_REG_CTRL);
  assign start_go = ctrl_wr && wr_data_in[`HT_CTRL_START] && !cs_hi;
  assign done     = conv_busy_out && (cnt_ff == '0) && !cs_hi && !start_go;

  // -----------------------------------------------------------------
  // control register
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ctrl_ff <= `HT_CTRL_RST;
    end else if (ctrl_wr) begin
      ctrl_ff <= wr_data_in & `HT_CTRL_MASK;  // see RL9
    end
  end

  assign heater_on_out = ctrl_ff[`HT_CTRL_HEAT];  // see RL9

  // -----------------------------------------------------------------
  // conversion timer and results
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      conv_busy_out <= 1'b0;
      nrdy_ff       <= `HT_NRDY_RST;
      cnt_ff        <= '0;
      kind_temp_ff  <= 1'b0;
      fast_ff       <= 1'b0;
      result_ff     <= `HT_RES_RST;
    end else if (cs_hi) begin
      conv_busy_out <= 1'b0;
    end else if (start_go) begin
      conv_busy_out <= 1'b1;
      nrdy_ff       <= 1'b1;  // see RL17
      kind_temp_ff  <= wr_data_in[`HT_CTRL_TEMP];
      fast_ff       <= wr_data_in[`HT_CTRL_FAST];
      cnt_ff        <= wr_data_in[`HT_CTRL_FAST] ? FAST_CYC - 1'b1 : NORM_CYC - 1'b1;  // see RL4
    end else if (done) begin
      conv_busy_out <= 1'b0;
      nrdy_ff       <= 1'b0;  // see RL2
      result_ff     <= (kind_temp_ff ? {2'h0, temp_code_in} : {4'h0, hum_code_in})
                       & (fast_ff ? `HT_FAST_MASK : 16'hffff);  // see RL3
    end else if (conv_busy_out) begin
      cnt_ff <= cnt_ff - 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // standby control
  // -----------------------------------------------------------------
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pend_ff  <= 1'b0;
      sleep_ff <= 1'b0;
      clr_ff   <= 2'h0;
    end else if (cs_hi) begin
      pend_ff  <= 1'b0;
      sleep_ff <= 1'b0;
      clr_ff   <= 2'h0;
    end else if (start_go) begin
      sleep_ff <= 1'b0;
      clr_ff   <= 2'h0;
    end else if (done) begin
      if (!kind_temp_ff) begin
        pend_ff <= 1'b1;  // see RL8
      end else if (!pend_ff) begin
        sleep_ff <= 1'b1;  // see RL7
      end
    end else if (ctrl_wr && wr_data_in == `HT_CTRL_CLEAR) begin
      if (pend_ff && clr_ff == `HT_CLR_LAST) begin
        sleep_ff <= 1'b1;  // see RL6
        pend_ff  <= 1'b0;
        clr_ff   <= 2'h0;
      end else begin
        clr_ff <= clr_ff + 2'h1;
      end
    end else if (wr_evt) begin
      clr_ff <= 2'h0;
    end
  end

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      standby_out <= 1'b0;
    end else begin
      standby_out <= cs_hi | sleep_ff;  // see RL5
    end
  end

  // -----------------------------------------------------------------
  // read answers
  // -----------------------------------------------------------------
  function automatic logic [7:0] reg_byte(input logic [7:0] ptr);
    case (ptr)
      `HT_REG_STATUS: reg_byte = {7'h00, nrdy_ff};  // see RL17
      `HT_REG_RES_HI: reg_byte = result_ff[15:8];
      `HT_REG_RES_LO: reg_byte = result_ff[7:0];
      `HT_REG_CTRL:   reg_byte = ctrl_ff;
      `HT_REG_IDENT:  reg_byte = {DEV_TYPE, DEV_REV};  // see RL10
      default:        reg_byte = 8'h00;
    endcase
  endfunction

  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsp_tgl_out  <= 1'b0;
      rsp_word_out <= 16'h0000;
    end else if (rd_evt) begin
      rsp_word_out <= {reg_byte(rd_ptr_in), reg_byte(rd_ptr_in + 8'h01)};  // see RL15
      rsp_tgl_out  <= ~rsp_tgl_out;
    end
  end

endmodule // ht_conv_core

// ---- verilog/ht_readout.sv ----
// serial target link and top level of the humidity and temperature readout
`timescale 1ns/1ps
`include "ht_cfg.svh"

// Operation
// RL1 - host starts a temperature conversion by writing 0x11 to the control register
// RL2 - host polls not-ready until zero; device clears it at conversion end
// RL3 - temperature result is a 14-bit code over high and low bytes
// RL4 - fast mode shortens conversion from 5.8 ms to 2.6 ms
// RL5 - chip select high enters standby and disables the serial link
// RL6 - after humidity conversion, two zero writes to control enter standby
// RL7 - device enters standby by itself after a temperature conversion
// RL8 - temperature after humidity conversion leaves the humidity standby pending
// RL9 - heater bit switches the heating element on and off
// RL10 - identification byte at 0x11 holds device type and revision
// RL11 - device answers at address 0x40 with a direction bit
// RL12 - device acknowledges own address, pointer and data bytes on ninth clock
// RL13 - write: first byte sets the pointer, next byte is stored
// RL14 - read: pointer write, repeated start, read address, one byte returned
// RL15 - host acknowledge of first byte makes device send the next byte
// RL16 - host starts humidity conversion by writing 0x01 to pointer 0x03
// RL17 - not-ready reads one during conversion, zero when results valid
// RL18 - host writes reserved bits as zero and only mapped registers
// RL19 - foreign addresses are not acknowledged; pointer persists between transfers
module ht_readout #(
  parameter logic [`HT_CNT_W-1:0] NORM_CYC = `HT_CNT_W'(`HT_CONV_NORM_CYC),
  parameter logic [`HT_CNT_W-1:0] FAST_CYC = `HT_CNT_W'(`HT_CONV_FAST_CYC)
) (
  // clocks and reset
  input  wire logic        mclk_in,
  input  wire logic        rstn_in,
  input  wire logic        link_clk_in,
  // serial pins
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_n_out,
  input  wire logic        chip_select_n_in,
  // analog front end codes
  input  wire logic [13:0] temp_code_in,
  input  wire logic [11:0] hum_code_in,
  // status
  output logic             heater_on_out,
  output logic             standby_out,
  output logic             conv_busy_out
);

  // -----------------------------------------------------------------
  // declarations
  // -----------------------------------------------------------------
  ht_pkg::ht_link_st_t st_ff;
  logic [2:0]          pin_s1_ff, pin_s2_ff;
  logic [1:0]          pin_d_ff;
  logic                scl_rise, scl_fall, scl_hi, bus_start, bus_stop, cs_hi, abort;
  logic [3:0]          bit_cnt_ff;
  logic [7:0]          shift_ff;
  logic                read_ff, ptr_phase_ff, second_ff, host_ack_ff;
  logic                rx_done, addr_done, addr_match;
  logic [7:0]          ptr_ff, wdata_ff;
  logic                wr_tgl_ff, rd_tgl_ff;
  logic                rsp_tgl;
  logic [15:0]         rsp_word;
  logic                rsp_s1_ff, rsp_s2_ff, rsp_d_ff;
  logic [15:0]         rsp_hold_ff;

  // -----------------------------------------------------------------
  // pin synchronisers
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      pin_s1_ff <= 3'h7;
      pin_s2_ff <= 3'h7;
      pin_d_ff  <= 2'h3;
    end else begin
      pin_s1_ff <= {chip_select_n_in, sda_in, scl_in};
      pin_s2_ff <= pin_s1_ff;
      pin_d_ff  <= pin_s2_ff[1:0];
    end
  end

  assign scl_rise  = pin_s2_ff[0] & ~pin_d_ff[0];
  assign scl_fall  = ~pin_s2_ff[0] & pin_d_ff[0];
  assign scl_hi    = pin_s2_ff[0] & pin_d_ff[0];
  assign bus_start = scl_hi & pin_d_ff[1] & ~pin_s2_ff[1];
  assign bus_stop  = scl_hi & ~pin_d_ff[1] & pin_s2_ff[1];
  assign cs_hi     = pin_s2_ff[2];
  assign abort     = cs_hi | bus_stop | bus_start;

  assign addr_match = (shift_ff[7:1] == `HT_TGT_ADDR);  // see RL11
  assign addr_done  = (st_ff == ht_pkg::LS_ADDR) && scl_fall && (bit_cnt_ff == 4'h8) && !abort;
  assign rx_done    = (st_ff == ht_pkg::LS_RECV) && scl_fall && (bit_cnt_ff == 4'h8) && !abort;

  // -----------------------------------------------------------------
  // link state machine
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      st_ff       <= ht_pkg::LS_IDLE;
      bit_cnt_ff  <= 4'h0;
      shift_ff    <= 8'h00;
      read_ff     <= 1'b0;
      second_ff   <= 1'b0;
      host_ack_ff <= 1'b0;
    end else if (cs_hi || bus_stop) begin
      st_ff <= ht_pkg::LS_IDLE;  // see RL5
    end else if (bus_start) begin
      st_ff      <= ht_pkg::LS_ADDR;
      bit_cnt_ff <= 4'h0;
    end else begin
      case (st_ff)
        ht_pkg::LS_ADDR, ht_pkg::LS_RECV: begin
          if (scl_rise && bit_cnt_ff != 4'h8) begin
            shift_ff   <= {shift_ff[6:0], pin_s2_ff[1]};
            bit_cnt_ff <= bit_cnt_ff + 4'h1;
          end else if (scl_fall && bit_cnt_ff == 4'h8) begin
            bit_cnt_ff <= 4'h0;
            if (st_ff == ht_pkg::LS_RECV) begin
              st_ff <= ht_pkg::LS_ACK;  // see RL12
            end else if (addr_match) begin
              st_ff     <= ht_pkg::LS_ACK;  // see RL12
              read_ff   <= shift_ff[0];  // see RL11
              second_ff <= 1'b0;
            end else begin
              st_ff <= ht_pkg::LS_IDLE;  // see RL19
            end
          end
        end
        ht_pkg::LS_ACK: begin
          if (scl_fall) begin
            if (read_ff) begin
              st_ff    <= ht_pkg::LS_SEND;  // see RL14
              shift_ff <= second_ff ? rsp_hold_ff[7:0] : rsp_hold_ff[15:8];
            end else begin
              st_ff <= ht_pkg::LS_RECV;
            end
          end
        end
        ht_pkg::LS_SEND: begin
          if (scl_fall) begin
            if (bit_cnt_ff == 4'h7) begin
              st_ff      <= ht_pkg::LS_RACK;
              bit_cnt_ff <= 4'h0;
            end else begin
              shift_ff   <= {shift_ff[6:0], 1'b1};
              bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
          end
        end
        ht_pkg::LS_RACK: begin
          if (scl_rise) begin
            host_ack_ff <= ~pin_s2_ff[1];
          end else if (scl_fall) begin
            if (host_ack_ff) begin
              st_ff     <= ht_pkg::LS_SEND;  // see RL15
              shift_ff  <= rsp_hold_ff[7:0];
              second_ff <= 1'b1;
            end else begin
              st_ff <= ht_pkg::LS_IDLE;  // see RL14
            end
          end
        end
        default: begin
          st_ff <= ht_pkg::LS_IDLE;
        end
      endcase
    end
  end

  // -----------------------------------------------------------------
  // pointer and write requests
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      ptr_phase_ff <= 1'b0;
      ptr_ff       <= `HT_REG_STATUS;
      wdata_ff     <= 8'h00;
      wr_tgl_ff    <= 1'b0;
    end else if (addr_done && addr_match) begin
      ptr_phase_ff <= ~shift_ff[0];
    end else if (rx_done) begin
      ptr_phase_ff <= 1'b0;
      if (ptr_phase_ff) begin
        ptr_ff <= shift_ff;  // see RL13
      end else begin
        wdata_ff  <= shift_ff;  // see RL13
        wr_tgl_ff <= ~wr_tgl_ff;
      end
    end
  end

  // -----------------------------------------------------------------
  // read requests and answers
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_tgl_ff <= 1'b0;
    end else if (addr_done && addr_match && shift_ff[0]) begin
      rd_tgl_ff <= ~rd_tgl_ff;  // see RL14
    end
  end

  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rsp_s1_ff   <= 1'b0;
      rsp_s2_ff   <= 1'b0;
      rsp_d_ff    <= 1'b0;
      rsp_hold_ff <= 16'h0000;
    end else begin
      rsp_s1_ff <= rsp_tgl;
      rsp_s2_ff <= rsp_s1_ff;
      rsp_d_ff  <= rsp_s2_ff;
      if (rsp_s2_ff ^ rsp_d_ff) begin
        rsp_hold_ff <= rsp_word;
      end
    end
  end

  // -----------------------------------------------------------------
  // data line drive
  // -----------------------------------------------------------------
  always_ff @(posedge link_clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= 1'b1;
    end else begin
      sda_out      <= 1'b0;
      sda_oe_n_out <= !((st_ff == ht_pkg::LS_ACK) ||  // see RL12
                        (st_ff == ht_pkg::LS_SEND && !shift_ff[7]));
    end
  end

  // -----------------------------------------------------------------
  // conversion core
  // -----------------------------------------------------------------
  ht_conv_core #(
    .NORM_CYC (NORM_CYC),
    .FAST_CYC (FAST_CYC)
  ) u_core (
    .mclk_in          (mclk_in),
    .rstn_in          (rstn_in),
    .wr_tgl_in        (wr_tgl_ff),
    .wr_ptr_in        (ptr_ff),
    .wr_data_in       (wdata_ff),
    .rd_tgl_in        (rd_tgl_ff),
    .rd_ptr_in        (ptr_ff),
    .rsp_tgl_out      (rsp_tgl),
    .rsp_word_out     (rsp_word),
    .chip_select_n_in (chip_select_n_in),
    .temp_code_in     (temp_code_in),
    .hum_code_in      (hum_code_in),
    .heater_on_out    (heater_on_out),
    .standby_out      (standby_out),
    .conv_busy_out    (conv_busy_out)
  );

endmodule // ht_readout

// ---- tb/ht_checker.sv ----
// assertion checker for the readout top
`timescale 1ns/1ps
`include "ht_cfg.svh"

module ht_checker #(
  parameter logic [`HT_CNT_W-1:0] NORM_CYC = `HT_CNT_W'(`HT_CONV_NORM_CYC),
  parameter logic [`HT_CNT_W-1:0] FAST_CYC = `HT_CNT_W'(`HT_CONV_FAST_CYC)
) (
  // clocks and reset
  input wire logic        mclk_in,
  input wire logic        rstn_in,
  input wire logic        link_clk_in,
  // serial pins
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe_n_out,
  input wire logic        chip_select_n_in,
  // front end and status
  input wire logic [13:0] temp_code_in,
  input wire logic [11:0] hum_code_in,
  input wire logic        heater_on_out,
  input wire logic        standby_out,
  input wire logic        conv_busy_out
);
  logic [`HT_CNT_W-1:0] busy_cnt_ff;

  // length of the running conversion
  always_ff @(posedge mclk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      busy_cnt_ff <= '0;
    end else if (conv_busy_out) begin
      busy_cnt_ff <= busy_cnt_ff + 19'h0_0001;
    end else begin
      busy_cnt_ff <= '0;
    end
  end

  a_sda_low_only: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
    !sda_oe_n_out |-> sda_out == 1'b0) else $error("sda driven high");
  a_drive_scl_low: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
    $changed(sda_oe_n_out) |-> !scl_in) else $error("sda drive changed while scl high");
  a_cs_releases_bus: assert property (@(posedge link_clk_in) disable iff (!rstn_in)
    chip_select_n_in [*8] |-> sda_oe_n_out) else $error("bus driven while deselected");
  a_cs_enters_standby: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $rose(chip_select_n_in) |-> ##[1:6] standby_out) else $error("no standby on cs");
  a_cs_holds_standby: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    chip_select_n_in [*6] |-> standby_out) else $error("standby lost under cs");
  a_cs_stops_conv: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    chip_select_n_in [*6] |-> !conv_busy_out) else $error("conversion runs under cs");
  a_cs_heater_quiet: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    chip_select_n_in [*8] |=> $stable(heater_on_out)) else $error("heater moved under cs");
  a_conv_length: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $fell(conv_busy_out) && !chip_select_n_in |->
      (busy_cnt_ff == NORM_CYC || busy_cnt_ff == FAST_CYC)) else $error("bad conversion time");
  a_start_wakes_up: assert property (@(posedge mclk_in) disable iff (!rstn_in)
    $rose(conv_busy_out) |-> ##[0:1] !standby_out) else $error("standby kept at start");
endmodule  // ht_checker

// ---- tb/ht_host_model.sv ----
// bus controller model on the far side of the serial link
`timescale 1ns/1ps
`include "ht_cfg.svh"

module ht_host_model #(
  parameter int QTR = 150
) (
  // from the device
  input  wire logic dut_sda_in,
  input  wire logic dut_oe_n_in,
  // bus wires
  output logic      scl_out,
  output logic      sda_out
);
  logic scl_ff = 1'b1;
  logic sda_ff = 1'b1;

  assign scl_out = scl_ff;
  // pulled-up open-drain wire
  assign sda_out = sda_ff & (dut_oe_n_in | dut_sda_in);

  task automatic bus_start();
    sda_ff = 1'b1;
    #QTR scl_ff = 1'b1;
    #QTR sda_ff = 1'b0;
    #QTR scl_ff = 1'b0;
    #QTR;
  endtask

  task automatic bus_stop();
    sda_ff = 1'b0;
    #QTR scl_ff = 1'b1;
    #QTR sda_ff = 1'b1;
    #(2 * QTR);
  endtask

  task automatic bus_bit(input logic b, output logic r);
    sda_ff = b;
    #QTR scl_ff = 1'b1;
    #QTR r = sda_out;
    #QTR scl_ff = 1'b0;
    #QTR;
  endtask

  task automatic send_byte(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bus_bit(b[i], r);
    bus_bit(1'b1, r);
    ack = ~r;
  endtask

  task automatic recv_byte(input logic last, output logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bus_bit(1'b1, b[i]);
    bus_bit(last, r);
  endtask

  task automatic write_reg(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d,
                           input logic with_d, output logic [2:0] acks);
    logic a0, a1, a2;
    a2 = 1'b1;
    bus_start();
    send_byte({ad, 1'b0}, a0);
    send_byte(p, a1);
    if (with_d) send_byte(d, a2);
    bus_stop();
    acks = {a0, a1, a2};
  endtask

  task automatic read_reg(input logic set_p, input logic [7:0] p, input logic two,
                          output logic [15:0] v, output logic [2:0] acks);
    logic a0, a1, a2;
    a0 = 1'b1;
    a1 = 1'b1;
    v = 16'h0000;
    bus_start();
    if (set_p) begin
      send_byte({`HT_TGT_ADDR, 1'b0}, a0);
      send_byte(p, a1);
      bus_start();
    end
    send_byte({`HT_TGT_ADDR, 1'b1}, a2);
    recv_byte(~two, v[15:8]);
    if (two) recv_byte(1'b1, v[7:0]);
    bus_stop();
    acks = {a0, a1, a2};
  endtask
endmodule  // ht_host_model

// ---- tb/tb.sv ----
// self-checking testbench for the readout top
`timescale 1ns/1ps
`include "ht_cfg.svh"

module tb;
  localparam logic [18:0] NORM   = 19'h0_05dc;
  localparam logic [18:0] FAST   = 19'h0_02bc;
  localparam logic [7:0]  ID_EXP = 8'h62;  // arbitrary id value
  localparam logic [7:0]  PTRS [6] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h11, 8'h05};
  localparam logic [7:0]  VALS [6] = '{8'h01, 8'h00, 8'h00, 8'h00, ID_EXP, 8'h00};
  logic        mclk_in, rstn_in, link_clk, cs_n, scl, sda, sda_o, sda_oe_n;
  logic        heat, stby, busy;
  logic [13:0] temp_code;
  logic [11:0] hum_code;
  logic [15:0] v;
  logic [2:0]  a;
  int          errors, checked, seed;

  initial begin
    mclk_in = 1'b0;
    forever #10 mclk_in = ~mclk_in;
  end
  initial begin
    link_clk = 1'b0;
    #1.7;
    forever #3 link_clk = ~link_clk;
  end

  ht_readout #(.NORM_CYC(NORM), .FAST_CYC(FAST)) dut (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .link_clk_in(link_clk), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_o), .sda_oe_n_out(sda_oe_n), .chip_select_n_in(cs_n),
    .temp_code_in(temp_code), .hum_code_in(hum_code), .heater_on_out(heat),
    .standby_out(stby), .conv_busy_out(busy));
  ht_host_model host (.dut_sda_in(sda_o), .dut_oe_n_in(sda_oe_n), .scl_out(scl), .sda_out(sda));

  // ----
  // checks and bus helpers
  // ----
  task automatic expect_eq(input logic [15:0] got, input logic [15:0] exp, input string s);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, s, got, exp);
    end
  endtask

  task automatic wr(input logic [6:0] ad, input logic [7:0] p, input logic [7:0] d,
                    input logic [2:0] ea);
    host.write_reg(ad, p, d, 1'b1, a);
    expect_eq({13'h0000, a}, {13'h0000, ea}, "write acks");
  endtask

  task automatic rd(input logic [7:0] p, input logic two, output logic [15:0] r);
    host.read_reg(1'b1, p, two, r, a);
    expect_eq({13'h0000, a}, 16'h0007, "read acks");
  endtask

  function automatic logic [15:0] exp_res(input logic [7:0] c, input logic [13:0] t,
                                          input logic [11:0] h);
    logic [15:0] r;
    r = c[4] ? {2'h0, t} : {4'h0, h};
    if (c[5]) r = r & 16'hfffc;
    return r;
  endfunction

  task automatic run_conv(input logic [7:0] c, input logic corner);
    int n;
    @(posedge mclk_in);
    temp_code <= corner ? 14'h3fff : 14'($random(seed));
    hum_code  <= corner ? 12'hfff : 12'($random(seed));
    wr(`HT_TGT_ADDR, 8'h03, c, 3'h7);
    expect_eq({15'h0000, busy}, 16'h0001, "busy");
    rd(8'h00, 1'b0, v);
    if (!c[5]) expect_eq(v, 16'h0100, "not ready");
    n = 0;
    while (v[8] !== 1'b0 && n < 20) begin
      rd(8'h00, 1'b0, v);
      n++;
    end
    expect_eq(v, 16'h0000, "ready");
    rd(8'h01, 1'b1, v);
    expect_eq(v, exp_res(c, temp_code, hum_code), "result");
  endtask

  task automatic end_test(input string s);
    $display("test %s done", s);
  endtask

  task automatic wrap_up();
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // ----
  // main sequence
  // ----
  initial begin
    seed = 75;
    errors = 0;
    checked = 0;
    rstn_in = 1'b0;
    cs_n = 1'b0;
    temp_code = 14'h0000;
    hum_code = 12'h000;
    repeat (8) @(posedge mclk_in);
    rstn_in <= 1'b1;
    repeat (20) @(posedge mclk_in);
    for (int i = 0; i < 6; i++) begin
      rd(PTRS[i], 1'b0, v);
      expect_eq(v, {VALS[i], 8'h00}, "reset value");
    end
    end_test("reset");
    wr(7'h41, 8'h03, 8'h01, 3'h0);
    expect_eq({15'h0000, busy}, 16'h0000, "foreign start");
    host.write_reg(`HT_TGT_ADDR, 8'h11, 8'h00, 1'b0, a);
    host.read_reg(1'b0, 8'h00, 1'b0, v, a);
    expect_eq(v, {ID_EXP, 8'h00}, "kept pointer");
    end_test("address");
    wr(`HT_TGT_ADDR, 8'h03, 8'h02, 3'h7);
    expect_eq({15'h0000, heat}, 16'h0001, "heater on");
    rd(8'h03, 1'b0, v);
    expect_eq(v, 16'h0200, "control");
    wr(`HT_TGT_ADDR, 8'h03, 8'h00, 3'h7);
    expect_eq({15'h0000, heat}, 16'h0000, "heater off");
    end_test("heater");
    run_conv(8'h11, 1'b1);
    expect_eq({15'h0000, stby}, 16'h0001, "temp standby");
    run_conv(8'h31, 1'b0);
    expect_eq({15'h0000, stby}, 16'h0001, "fast standby");
    end_test("temperature");
    run_conv(8'h01, 1'b0);
    expect_eq({15'h0000, stby}, 16'h0000, "hum awake");
    run_conv(8'h11, 1'b0);
    expect_eq({15'h0000, stby}, 16'h0000, "temp after hum");
    wr(`HT_TGT_ADDR, 8'h03, 8'h00, 3'h7);
    expect_eq({15'h0000, stby}, 16'h0000, "one clear");
    wr(`HT_TGT_ADDR, 8'h03, 8'h00, 3'h7);
    expect_eq({15'h0000, stby}, 16'h0001, "two clears");
    end_test("humidity");
    wr(`HT_TGT_ADDR, 8'h03, 8'h01, 3'h7);
    @(posedge mclk_in);
    cs_n <= 1'b1;
    repeat (10) @(posedge mclk_in);
    expect_eq({14'h0000, stby, busy}, 16'h0002, "deselect");
    wr(`HT_TGT_ADDR, 8'h00, 8'h00, 3'h0);
    @(posedge mclk_in);
    cs_n <= 1'b0;
    repeat (10) @(posedge mclk_in);
    rd(8'h00, 1'b0, v);
    expect_eq(v, 16'h0100, "aborted");
    end_test("chip select");
    wrap_up();
  end

  initial begin
    #1_900_000;
    errors++;
    $display("unexpected at %0t: timeout", $time);
    wrap_up();
  end
endmodule  // tb

bind ht_readout ht_checker #(.NORM_CYC(NORM_CYC), .FAST_CYC(FAST_CYC)) u_chk (
  .mclk_in(mclk_in), .rstn_in(rstn_in), .link_clk_in(link_clk_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_n_out(sda_oe_n_out),
  .chip_select_n_in(chip_select_n_in), .temp_code_in(temp_code_in),
  .hum_code_in(hum_code_in), .heater_on_out(heater_on_out), .standby_out(standby_out),
  .conv_busy_out(conv_busy_out));
